/* core/event_router_pkg.sv */
// Shared constants and types for the peripheral event router and its peer end
package event_router_pkg;
   localparam int AC_CHANNELS = 8; // Comparator channels feeding the router
   localparam int PWM_CHANNELS = 21; // Pulse-width channels reachable, highest mapped is 20
   localparam int PIN_GROUPS = 5; // Pin-change groups routed to capture inputs
   localparam int AST_EVENTS = 3; // Overflow, periodic and alarm events
   localparam int TMR0_CAPTURES = 3; // Capture inputs A0..A2 of timer group zero
   localparam int TMR1_CAPTURES = 2; // Capture inputs A1..A2 of timer group one
   localparam int SYNC_STAGES = 3; // Flip-flops on each asynchronous event input

   typedef logic [4:0] pwm_index_t; // Index of one pulse-width channel

   // Comparator channel to pulse-width channel mapping
   localparam pwm_index_t PWM_MAP [AC_CHANNELS] = '{
      5'h00, 5'h06, 5'h08, 5'h09, 5'h0b, 5'h0e, 5'h13, 5'h14
   };

   // Positions inside the pin-change group vector
   localparam int PIN_GRP_PA_00_07 = 0;
   localparam int PIN_GRP_PA_08_15 = 1;
   localparam int PIN_GRP_PA_16_23 = 2;
   localparam int PIN_GRP_PB_00_07 = 3;
   localparam int PIN_GRP_PB_08_15 = 4;

   // Positions inside the asynchronous timer event vector
   localparam int AST_OVERFLOW = 0;
   localparam int AST_PERIODIC = 1;
   localparam int AST_ALARM = 2;

   // Positions inside the clock request vector
   localparam int CLK_REQ_CMP = 0;
   localparam int CLK_REQ_CONV = 1;
   localparam int CLK_REQ_TOUCH = 2;
   localparam int CLK_REQ_USERS = 3;

   // User-side qualifying field values
   localparam logic [1:0] CMP_CONFIG_EVENT_SINGLE = 2'h3; // Event-triggered single measurement
   localparam logic [2:0] TRIGGER_MODE_EVENT = 3'h7; // Converter started by events

   // Values after reset
   localparam logic RESET_PULSE = 1'b0;
   localparam logic [SYNC_STAGES-1:0] RESET_SYNC = 3'h0;
endpackage : event_router_pkg

/* core/event_router_if.sv */
// Carrier between the event router and the generator/user peer end
`timescale 1ns/1ps
interface event_router_if;
   import event_router_pkg::*;
   // Generator side, already gated by the generator enables
   logic [AC_CHANNELS-1:0] ac_pos_evt; // Positive input above negative input, pulse
   logic [AC_CHANNELS-1:0] ac_neg_evt; // Negative input above positive input, pulse
   logic [PIN_GROUPS-1:0] pin_evt; // Pin-change per group, pulse
   logic [AST_EVENTS-1:0] ast_evt_async; // Timer events, asynchronous to the core clock
   logic pwm0_match_evt; // Channel 0 counter equals duty value, pulse
   // User side input enables
   logic [PWM_CHANNELS-1:0] pwm_in_en;
   logic [TMR0_CAPTURES-1:0] tmr0_in_en;
   logic [TMR1_CAPTURES-1:0] tmr1_in_en;
   logic cmp_in_en;
   logic conv_in_en;
   logic touch_matrix_en;
   logic touch_iter_en;
   // Delivered events, one-cycle pulses from the router
   logic [PWM_CHANNELS-1:0] pwm_inc;
   logic [PWM_CHANNELS-1:0] pwm_dec;
   logic [TMR0_CAPTURES-1:0] tmr0_capture;
   logic [TMR1_CAPTURES-1:0] tmr1_capture;
   logic cmp_trigger;
   logic conv_trigger;
   logic touch_matrix_evt;
   logic touch_iter_start;

   modport router (
      input ac_pos_evt, ac_neg_evt, pin_evt, ast_evt_async, pwm0_match_evt,
      input pwm_in_en, tmr0_in_en, tmr1_in_en, cmp_in_en, conv_in_en,
      input touch_matrix_en, touch_iter_en,
      output pwm_inc, pwm_dec, tmr0_capture, tmr1_capture, cmp_trigger,
      output conv_trigger, touch_matrix_evt, touch_iter_start
   );
   modport peer (
      output ac_pos_evt, ac_neg_evt, pin_evt, ast_evt_async, pwm0_match_evt,
      output pwm_in_en, tmr0_in_en, tmr1_in_en, cmp_in_en, conv_in_en,
      output touch_matrix_en, touch_iter_en,
      input pwm_inc, pwm_dec, tmr0_capture, tmr1_capture, cmp_trigger,
      input conv_trigger, touch_matrix_evt, touch_iter_start
   );
endinterface : event_router_if

/* core/event_router.sv */
// Fixed peripheral event router: hard-wired generator to user event network
`timescale 1ns/1ps
// Operation
// [RQ1] Fixed hard-wired mapping, no configurable interconnect
// [RQ2] One event fans out to all users
// [RQ3] Several generators OR into one user
// [RQ4] Route needs generator and user enables
// [RQ5] Only enabled users react to shared event
// [RQ6] Comparator above event increments mapped duty
// [RQ7] Comparator below event decrements mapped duty
// [RQ8] Comparator below events also reach touch unit
// [RQ9] Port A groups capture timer zero A0-A2
// [RQ10] Port B groups capture timer one A1-A2
// [RQ11] Timer events trigger comparator when configured
// [RQ12] Timer events start converter in event mode
// [RQ13] Timer events start one touch iteration
// [RQ14] Pulse-width zero match starts converter
// [RQ15] Asynchronous events request user clock restart
// [RQ16] One-cycle pulses, single register stage
module event_router (
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   event_router_if.router bus,
   output logic [event_router_pkg::CLK_REQ_USERS-1:0] o_async_clk_req
);
   import event_router_pkg::*;

   // Spreads comparator channel events onto their fixed pulse-width channels
   function automatic logic [PWM_CHANNELS-1:0] map_to_pwm(
      input logic [AC_CHANNELS-1:0] ac_evt
   );
      logic [PWM_CHANNELS-1:0] result;
      result = '0;
      for (int i = 0; i < AC_CHANNELS; i++) begin
         result[PWM_MAP[i]] = result[PWM_MAP[i]] | ac_evt[i]; // RQ1
      end
      return result;
   endfunction : map_to_pwm

   // Asynchronous timer event synchronisers, one shift register per event
   logic [SYNC_STAGES-1:0] ast_sync_reg [AST_EVENTS];
   logic [AST_EVENTS-1:0] ast_level_reg; // Accepted level after the stages agree
   logic [AST_EVENTS-1:0] ast_agree; // Second and third stages hold the same value
   logic [AST_EVENTS-1:0] ast_rise; // New event accepted this cycle
   logic [AST_EVENTS-1:0] ast_arriving; // Event seen in the second stage, not yet accepted

   generate
      for (genvar g = 0; g < AST_EVENTS; g++) begin : g_ast_sync
         // Three-stage shift; only the second stage reads the first
         always_ff @(posedge i_core_clk or negedge i_reset_n) begin
            if (!i_reset_n) begin
               ast_sync_reg[g] <= RESET_SYNC;
            end else begin
               ast_sync_reg[g] <= {ast_sync_reg[g][1:0], bus.ast_evt_async[g]};
            end
         end

         // A change only counts once the last two stages agree, filtering metastable echoes
         assign ast_agree[g] = (ast_sync_reg[g][1] == ast_sync_reg[g][2]);
         assign ast_rise[g] = ast_agree[g] & ast_sync_reg[g][2] & ~ast_level_reg[g];
         assign ast_arriving[g] = ast_sync_reg[g][1] & ~ast_level_reg[g];

         // Accepted level tracks the agreed value
         always_ff @(posedge i_core_clk or negedge i_reset_n) begin
            if (!i_reset_n) begin
               ast_level_reg[g] <= RESET_PULSE;
            end else if (ast_agree[g]) begin
               ast_level_reg[g] <= ast_sync_reg[g][2];
            end
         end
      end
   endgenerate

   // Any accepted timer event; the three kinds share every user
   wire ast_any = |ast_rise; // RQ3
   wire ast_pending = |ast_arriving;

   // Next values of the delivered pulses
   wire [PWM_CHANNELS-1:0] pwm_inc_next;
   wire [PWM_CHANNELS-1:0] pwm_dec_next;
   wire [TMR0_CAPTURES-1:0] tmr0_capture_next;
   wire [TMR1_CAPTURES-1:0] tmr1_capture_next;
   wire cmp_trigger_next;
   wire conv_trigger_next;
   wire touch_matrix_next;
   wire touch_iter_next;

   // Duty steps, gated by the receiving channel's own input enable
   assign pwm_inc_next = map_to_pwm(bus.ac_pos_evt) & bus.pwm_in_en; // RQ6 RQ4 RQ5
   assign pwm_dec_next = map_to_pwm(bus.ac_neg_evt) & bus.pwm_in_en; // RQ7 RQ4 RQ5

   // Pin-change groups to timer captures
   assign tmr0_capture_next = {bus.pin_evt[PIN_GRP_PA_16_23], bus.pin_evt[PIN_GRP_PA_08_15],
      bus.pin_evt[PIN_GRP_PA_00_07]} & bus.tmr0_in_en; // RQ9 RQ5
   assign tmr1_capture_next = {bus.pin_evt[PIN_GRP_PB_08_15], bus.pin_evt[PIN_GRP_PB_00_07]}
      & bus.tmr1_in_en; // RQ10 RQ5

   // Timer events fan out to comparator, converter and touch unit
   assign cmp_trigger_next = ast_any & bus.cmp_in_en; // RQ11 RQ2
   assign conv_trigger_next = (ast_any | bus.pwm0_match_evt) & bus.conv_in_en; // RQ12 RQ14 RQ3
   assign touch_iter_next = ast_any & bus.touch_iter_en; // RQ13 RQ2

   // Every channel's below event ORs into the touch unit's matrix input
   assign touch_matrix_next = (|bus.ac_neg_evt) & bus.touch_matrix_en; // RQ8 RQ3 RQ2

   // Clock requests: raised as soon as an event is arriving, dropped once delivered
   wire [CLK_REQ_USERS-1:0] clk_req_set;
   wire [CLK_REQ_USERS-1:0] clk_req_done;
   assign clk_req_set[CLK_REQ_CMP] = ast_pending & bus.cmp_in_en;
   assign clk_req_set[CLK_REQ_CONV] = ast_pending & bus.conv_in_en;
   assign clk_req_set[CLK_REQ_TOUCH] = ast_pending & bus.touch_iter_en;
   assign clk_req_done = {bus.touch_iter_start, bus.conv_trigger, bus.cmp_trigger};

   // Single register stage for every delivered event
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         bus.pwm_inc <= '0;
         bus.pwm_dec <= '0;
         bus.tmr0_capture <= '0;
         bus.tmr1_capture <= '0;
      end else begin
         bus.pwm_inc <= pwm_inc_next; // RQ16
         bus.pwm_dec <= pwm_dec_next; // RQ16
         bus.tmr0_capture <= tmr0_capture_next; // RQ16
         bus.tmr1_capture <= tmr1_capture_next; // RQ16
      end
   end

   // Single-bit users share the same one-stage timing
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         bus.cmp_trigger <= RESET_PULSE;
         bus.conv_trigger <= RESET_PULSE;
         bus.touch_matrix_evt <= RESET_PULSE;
         bus.touch_iter_start <= RESET_PULSE;
      end else begin
         bus.cmp_trigger <= cmp_trigger_next; // RQ16
         bus.conv_trigger <= conv_trigger_next; // RQ16
         bus.touch_matrix_evt <= touch_matrix_next; // RQ16
         bus.touch_iter_start <= touch_iter_next; // RQ16
      end
   end

   // Per-user clock request; a new arrival wins over the drop in the same cycle
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_async_clk_req <= '0;
      end else begin
         o_async_clk_req <= clk_req_set | (o_async_clk_req & ~clk_req_done); // RQ15
      end
   end
endmodule : event_router

/* core/event_peer_end.sv */
// Generator and user end of the event network: enables, qualifiers, delivery
`timescale 1ns/1ps
module event_peer_end (
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   event_router_if.peer bus,
   input wire logic [event_router_pkg::AC_CHANNELS-1:0] i_ac_pos_raw,
   input wire logic [event_router_pkg::AC_CHANNELS-1:0] i_ac_neg_raw,
   input wire logic [event_router_pkg::AC_CHANNELS-1:0] i_ac_gen_en,
   input wire logic [event_router_pkg::PIN_GROUPS-1:0] i_pin_change,
   input wire logic [event_router_pkg::PIN_GROUPS-1:0] i_pin_gen_en,
   input wire logic [event_router_pkg::AST_EVENTS-1:0] i_ast_evt,
   input wire logic [event_router_pkg::AST_EVENTS-1:0] i_ast_gen_en,
   input wire logic i_pwm0_match,
   input wire logic i_pwm0_gen_en,
   input wire logic [event_router_pkg::PWM_CHANNELS-1:0] i_pwm_in_en,
   input wire logic [event_router_pkg::TMR0_CAPTURES-1:0] i_tmr0_in_en,
   input wire logic [event_router_pkg::TMR1_CAPTURES-1:0] i_tmr1_in_en,
   input wire logic i_comparator_event_input_enable,
   input wire logic [1:0] i_comparator_config_field,
   input wire logic [2:0] i_trigger_mode_field,
   input wire logic i_touch_matrix_en,
   input wire logic i_touch_iter_en,
   output logic [event_router_pkg::PWM_CHANNELS-1:0] o_pwm_inc,
   output logic [event_router_pkg::PWM_CHANNELS-1:0] o_pwm_dec,
   output logic [event_router_pkg::TMR0_CAPTURES-1:0] o_tmr0_capture,
   output logic [event_router_pkg::TMR1_CAPTURES-1:0] o_tmr1_capture,
   output logic o_cmp_start,
   output logic o_conv_start,
   output logic o_touch_matrix,
   output logic o_touch_iter
);
   import event_router_pkg::*;

   // Comparator reacts only in event single measurement with its enable bit set
   wire cmp_qualified = i_comparator_event_input_enable
      & (i_comparator_config_field == CMP_CONFIG_EVENT_SINGLE); // RQ11
   // Converter reacts only when its trigger mode selects events
   wire conv_qualified = (i_trigger_mode_field == TRIGGER_MODE_EVENT); // RQ12 RQ14

   // Timer events cross unregistered; the router synchronises them
   assign bus.ast_evt_async = i_ast_evt & i_ast_gen_en; // RQ4

   // Generator outputs are registered so each event is a clean one-cycle pulse
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         bus.ac_pos_evt <= '0;
         bus.ac_neg_evt <= '0;
         bus.pin_evt <= '0;
         bus.pwm0_match_evt <= RESET_PULSE;
      end else begin
         bus.ac_pos_evt <= i_ac_pos_raw & i_ac_gen_en; // RQ4
         bus.ac_neg_evt <= i_ac_neg_raw & i_ac_gen_en; // RQ4
         bus.pin_evt <= i_pin_change & i_pin_gen_en; // RQ4
         bus.pwm0_match_evt <= i_pwm0_match & i_pwm0_gen_en; // RQ4 RQ14
      end
   end

   // User input enables, registered so they change cleanly with the clock
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         bus.pwm_in_en <= '0;
         bus.tmr0_in_en <= '0;
         bus.tmr1_in_en <= '0;
         bus.cmp_in_en <= RESET_PULSE;
         bus.conv_in_en <= RESET_PULSE;
         bus.touch_matrix_en <= RESET_PULSE;
         bus.touch_iter_en <= RESET_PULSE;
      end else begin
         bus.pwm_in_en <= i_pwm_in_en;
         bus.tmr0_in_en <= i_tmr0_in_en;
         bus.tmr1_in_en <= i_tmr1_in_en;
         bus.cmp_in_en <= cmp_qualified; // RQ4 RQ11
         bus.conv_in_en <= conv_qualified; // RQ4 RQ12
         bus.touch_matrix_en <= i_touch_matrix_en;
         bus.touch_iter_en <= i_touch_iter_en;
      end
   end

   // Delivered events captured into the user modules
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_pwm_inc <= '0;
         o_pwm_dec <= '0;
         o_tmr0_capture <= '0;
         o_tmr1_capture <= '0;
         o_cmp_start <= RESET_PULSE;
         o_conv_start <= RESET_PULSE;
         o_touch_matrix <= RESET_PULSE;
         o_touch_iter <= RESET_PULSE;
      end else begin
         o_pwm_inc <= bus.pwm_inc;
         o_pwm_dec <= bus.pwm_dec;
         o_tmr0_capture <= bus.tmr0_capture;
         o_tmr1_capture <= bus.tmr1_capture;
         o_cmp_start <= bus.cmp_trigger;
         o_conv_start <= bus.conv_trigger;
         o_touch_matrix <= bus.touch_matrix_evt;
         o_touch_iter <= bus.touch_iter_start;
      end
   end
endmodule : event_peer_end

/* tb/event_router_props.sv */
// Concurrent checks on the carrier between the router and the peer end
`timescale 1ns/1ps
module event_router_props
   import event_router_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   input wire logic [AC_CHANNELS-1:0] ac_pos_evt,
   input wire logic [AC_CHANNELS-1:0] ac_neg_evt,
   input wire logic [PIN_GROUPS-1:0] pin_evt,
   input wire logic [AST_EVENTS-1:0] ast_evt_async,
   input wire logic pwm0_match_evt,
   input wire logic [PWM_CHANNELS-1:0] pwm_in_en,
   input wire logic [TMR0_CAPTURES-1:0] tmr0_in_en,
   input wire logic [TMR1_CAPTURES-1:0] tmr1_in_en,
   input wire logic cmp_in_en,
   input wire logic conv_in_en,
   input wire logic touch_matrix_en,
   input wire logic touch_iter_en,
   input wire logic [PWM_CHANNELS-1:0] pwm_inc,
   input wire logic [PWM_CHANNELS-1:0] pwm_dec,
   input wire logic [TMR0_CAPTURES-1:0] tmr0_capture,
   input wire logic [TMR1_CAPTURES-1:0] tmr1_capture,
   input wire logic cmp_trigger,
   input wire logic conv_trigger,
   input wire logic touch_matrix_evt,
   input wire logic touch_iter_start
);
   // All checks share the core clock and its reset
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_reset_n);
   logic [PWM_CHANNELS-1:0] map_mask; // Channels some comparator reaches
   always_comb begin
      map_mask = '0;
      for (int i = 0; i < AC_CHANNELS; i++) begin
         map_mask[PWM_MAP[i]] = 1'b1;
      end
   end
   // Timer events cross unregistered, so their rise is the cause
   sequence s_timer_rise;
      $rose(|ast_evt_async);
   endsequence
   // Each comparator reaches only its mapped duty channel, one stage later
   for (genvar i = 0; i < AC_CHANNELS; i++) begin : g_ch
      a_inc_mapped: assert property (pwm_inc[PWM_MAP[i]] == $past(ac_pos_evt[i] && pwm_in_en[PWM_MAP[i]]))
         else $error("duty increment not routed");
      a_dec_mapped: assert property (pwm_dec[PWM_MAP[i]] == $past(ac_neg_evt[i] && pwm_in_en[PWM_MAP[i]]))
         else $error("duty decrement not routed");
   end
   a_unmapped_quiet: assert property (((pwm_inc | pwm_dec) & ~map_mask) == '0)
      else $error("unmapped duty channel pulsed");
   a_touch_or: assert property (touch_matrix_evt == $past(|ac_neg_evt && touch_matrix_en))
      else $error("touch matrix event wrong");
   a_cap_zero: assert property (tmr0_capture == $past(pin_evt[2:0] & tmr0_in_en))
      else $error("timer zero capture wrong");
   a_cap_one: assert property (tmr1_capture == $past(pin_evt[4:3] & tmr1_in_en))
      else $error("timer one capture wrong");
   a_conv_match: assert property (pwm0_match_evt && conv_in_en |=> conv_trigger)
      else $error("channel zero match lost");
   a_conv_timer: assert property (s_timer_rise ##0 conv_in_en |-> ##[2:5] conv_trigger)
      else $error("timer event missed converter");
   a_iter_timer: assert property (s_timer_rise ##0 touch_iter_en |-> ##[2:5] touch_iter_start)
      else $error("timer event missed touch unit");
   a_iter_single: assert property (touch_iter_start |=> !touch_iter_start)
      else $error("touch iteration pulse too long");
   a_cmp_gated: assert property (cmp_trigger |-> $past(cmp_in_en))
      else $error("comparator triggered while disabled");
endmodule : event_router_props

/* tb/peripheral_event_router_tb.sv */
// Self-checking bench: router and peer end joined through the carrier
`timescale 1ns/1ps
module peripheral_event_router_tb;
   import event_router_pkg::*;
   logic i_core_clk = 1'b0; // 50 MHz core clock
   logic i_reset_n = 1'b0; // Held low at start
   logic [AC_CHANNELS-1:0] ac_pos, ac_neg, ac_gen; // Comparator pulses and enables
   logic [PIN_GROUPS-1:0] pin_chg, pin_gen;
   logic [AST_EVENTS-1:0] ast_evt, ast_gen;
   logic m0, m0_gen, cmp_en, tm_en, ti_en, cmp_st, conv_st, tmx, tit, sync_on;
   logic [1:0] cmp_cfg;
   logic [2:0] trg_mode;
   logic [PWM_CHANNELS-1:0] pwm_en, pwm_inc, pwm_dec, e_inc, e_dec;
   logic [TMR0_CAPTURES-1:0] t0_en, cap0;
   logic [TMR1_CAPTURES-1:0] t1_en, cap1;
   logic [CLK_REQ_USERS-1:0] clk_req;
   // Raw pulse history; index 2 is the sample two edges back
   logic [2:0][AC_CHANNELS-1:0] h_pos, h_neg;
   logic [2:0][PIN_GROUPS-1:0] h_pin;
   logic [2:0] h_m0;
   int err_total = 0;
   int comparisons = 0;
   event_router_if bus ();
   event_router event_router_inst (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .bus(bus),
      .o_async_clk_req(clk_req));
   event_peer_end event_peer_end_inst (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
      .bus(bus), .i_ac_pos_raw(ac_pos), .i_ac_neg_raw(ac_neg), .i_ac_gen_en(ac_gen),
      .i_pin_change(pin_chg), .i_pin_gen_en(pin_gen), .i_ast_evt(ast_evt), .i_ast_gen_en(ast_gen),
      .i_pwm0_match(m0), .i_pwm0_gen_en(m0_gen), .i_pwm_in_en(pwm_en), .i_tmr0_in_en(t0_en),
      .i_tmr1_in_en(t1_en), .i_comparator_event_input_enable(cmp_en),
      .i_comparator_config_field(cmp_cfg), .i_trigger_mode_field(trg_mode),
      .i_touch_matrix_en(tm_en), .i_touch_iter_en(ti_en), .o_pwm_inc(pwm_inc),
      .o_pwm_dec(pwm_dec), .o_tmr0_capture(cap0), .o_tmr1_capture(cap1), .o_cmp_start(cmp_st),
      .o_conv_start(conv_st), .o_touch_matrix(tmx), .o_touch_iter(tit));
   event_router_props event_router_props_inst (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
      .ac_pos_evt(bus.ac_pos_evt), .ac_neg_evt(bus.ac_neg_evt), .pin_evt(bus.pin_evt),
      .ast_evt_async(bus.ast_evt_async), .pwm0_match_evt(bus.pwm0_match_evt),
      .pwm_in_en(bus.pwm_in_en), .tmr0_in_en(bus.tmr0_in_en), .tmr1_in_en(bus.tmr1_in_en),
      .cmp_in_en(bus.cmp_in_en), .conv_in_en(bus.conv_in_en),
      .touch_matrix_en(bus.touch_matrix_en), .touch_iter_en(bus.touch_iter_en),
      .pwm_inc(bus.pwm_inc), .pwm_dec(bus.pwm_dec), .tmr0_capture(bus.tmr0_capture),
      .tmr1_capture(bus.tmr1_capture), .cmp_trigger(bus.cmp_trigger),
      .conv_trigger(bus.conv_trigger), .touch_matrix_evt(bus.touch_matrix_evt),
      .touch_iter_start(bus.touch_iter_start));
   always #10 i_core_clk = ~i_core_clk;
   // Compare seen against expected and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic end_sim();
      if (err_total == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : end_sim
   // Inputs always move a fixed 1 ns after the rising edge
   task automatic step();
      @(posedge i_core_clk);
      #1;
   endtask : step
   always @(posedge i_core_clk) begin
      h_pos <= {h_pos[1:0], ac_pos};
      h_neg <= {h_neg[1:0], ac_neg};
      h_pin <= {h_pin[1:0], pin_chg};
      h_m0 <= {h_m0[1:0], m0};
   end
   // Model of the sync path: three cycles from raw pulse to user pulse
   always @(negedge i_core_clk) begin
      if (sync_on) begin
         e_inc = '0;
         e_dec = '0;
         for (int i = 0; i < AC_CHANNELS; i++) begin
            e_inc[PWM_MAP[i]] = h_pos[2][i] & ac_gen[i] & pwm_en[PWM_MAP[i]];
            e_dec[PWM_MAP[i]] = h_neg[2][i] & ac_gen[i] & pwm_en[PWM_MAP[i]];
         end
         check(pwm_inc, e_inc);
         check(pwm_dec, e_dec);
         check(cap0, h_pin[2][2:0] & pin_gen[2:0] & t0_en);
         check(cap1, h_pin[2][4:3] & pin_gen[4:3] & t1_en);
         check(tmx, tm_en & |(h_neg[2] & ac_gen));
         check(conv_st, h_m0[2] & m0_gen & (trg_mode == TRIGGER_MODE_EVENT));
         check({cmp_st, tit}, 2'h0);
      end
   end
   // Random back-to-back pulses under one fixed enable set
   task automatic sync_phase(input int p);
      {ac_gen, pin_gen, m0_gen, tm_en, t0_en, t1_en} = (p == 0) ? '1 : 20'($urandom);
      pwm_en = (p == 0) ? '1 : 21'($urandom);
      trg_mode = p[0] ? 3'h7 : 3'h3;
      repeat (3) step();
      sync_on = 1'b1;
      // Each random set is held across one edge before the next one replaces it
      repeat (40) begin
         {ac_pos, ac_neg, pin_chg, m0} = 22'($urandom);
         step();
      end
      {ac_pos, ac_neg, pin_chg, m0} = '0;
      repeat (3) step();
      sync_on = 1'b0;
   endtask : sync_phase
   // One timer event under a chosen qualifier set
   task automatic timer_evt(input int j);
      logic [3:0] n_cmp, n_conv, n_tit;
      logic [CLK_REQ_USERS-1:0] n_req;
      logic g;
      {n_cmp, n_conv, n_tit, n_req} = '0;
      cmp_en = j[0];
      cmp_cfg = j[1] ? 2'h3 : 2'($urandom_range(2));
      trg_mode = j[2] ? 3'h7 : 3'($urandom_range(6));
      ti_en = j[3];
      ast_gen = (j == 15) ? 3'h0 : 3'h7;
      g = ast_gen[j % 3];
      repeat (4) step();
      ast_evt[j % 3] = 1'b1;
      for (int c = 0; c < 12; c++) begin
         step();
         if (c == 3) ast_evt = '0;
         n_cmp = n_cmp + cmp_st;
         n_conv = n_conv + conv_st;
         n_tit = n_tit + tit;
         n_req = n_req | clk_req;
      end
      check(n_cmp, g & cmp_en & (cmp_cfg == CMP_CONFIG_EVENT_SINGLE));
      check(n_conv, g & (trg_mode == TRIGGER_MODE_EVENT));
      check(n_tit, g & ti_en);
      check(n_req[CLK_REQ_CONV], g & (trg_mode == TRIGGER_MODE_EVENT));
      check(n_req[CLK_REQ_CMP], g & cmp_en & (cmp_cfg == CMP_CONFIG_EVENT_SINGLE));
      check(n_req[CLK_REQ_TOUCH], g & ti_en);
      check(clk_req, 3'h0);
   endtask : timer_evt
   // Hang guard well above the expected run length
   initial begin
      #100us;
      err_total++;
      end_sim();
   end
   initial begin
      {ac_pos, ac_neg, ac_gen, pin_chg, pin_gen, ast_evt, ast_gen, m0, m0_gen} = '0;
      {cmp_en, tm_en, ti_en, cmp_cfg, trg_mode, pwm_en, t0_en, t1_en, sync_on} = '0;
      void'($urandom(32'hb3c5));
      repeat (16) step();
      i_reset_n = 1'b1;
      repeat (3) step();
      for (int p = 0; p < 8; p++) sync_phase(p);
      // Second reset in mid-run must clear every delivery
      i_reset_n = 1'b0;
      step();
      check(pwm_inc | pwm_dec, '0);
      check({cap0, cap1, cmp_st, conv_st, tmx, tit, clk_req}, '0);
      i_reset_n = 1'b1;
      repeat (3) step();
      for (int j = 0; j < 16; j++) timer_evt(j);
      end_sim();
   end
endmodule : peripheral_event_router_tb
